// file: ctpm_clock_power.sv
// Clock trim, reference clock output and Sleep/Idle power mode control.
// Assumes one clk at 100 MHz, synchronous srst, crystal and wake inputs from pins.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`include "ctpm_defs.svh"

module ctpm_clock_power
  import ctpm_pkg::*;
#(
  parameter int DIV_WIDTH = 15
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  input  wire logic        xtal_clk_in,
  input  wire logic        sleep_request,
  input  wire logic        idle_request,
  input  wire logic        wake_interrupt,
  input  wire logic        wake_reset,
  input  wire logic        watchdog_timeout,
  input  wire logic        watchdog_enable,
  input  wire logic        clock_monitor_enable,
  input  wire logic        clock_config_locked,
  input  wire logic        timer_stop_in_idle,
  output logic [5:0]       rc_trim_code,
  output logic             reference_clock_pin,
  output logic             reference_clock_oe_n,
  output logic             cpu_clock_enable,
  output logic             system_clock_enable,
  output logic             oscillator_enable,
  output logic             peripheral_clock_enable,
  output logic             timer_clock_enable,
  output logic             clock_monitor_active,
  output logic             low_power_rc_enable,
  output logic             watchdog_clear,
  output logic             core_regulator_standby,
  output logic             flash_regulator_standby,
  output logic [2:0]       new_oscillator_select,
  output logic             resume_at_isr
);

  ctpm_state_type state_reg;
  ctpm_state_type state_next;
  logic [15:0]    refctl_reg;
  logic [15:0]    resetctl_reg;
  logic [15:0]    oscctl_reg;
  logic [2:0]     sleep_osc_reg;
  logic [1:0]     wake_cnt_reg;
  logic           wake_irq_reg;
  logic [DIV_WIDTH-1:0] div_cnt_reg;
  logic           ref_out_reg;
  logic [1:0]     xtal_sync_reg;
  logic           xtal_prev_reg;
  logic           in_sleep;
  logic           in_idle;
  logic           wake_event;
  logic           ref_tick;
  logic           ref_run;
  logic [3:0]     div_code;
  logic [DIV_WIDTH-1:0] div_limit;

  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] target);
    addr_hit = (a == target);
  endfunction : addr_hit

  assign in_sleep   = (state_reg == CTPM_SLEEP);
  assign in_idle    = (state_reg == CTPM_IDLE);
  assign wake_event = wake_interrupt | wake_reset | watchdog_timeout;
  assign div_code   = refctl_reg[`CTPM_REF_DIV_HI:`CTPM_REF_DIV_LO];
  // Half period of two to the n: toggle every 2^(n-1) ticks
  assign div_limit  = (div_code == 4'h0) ? '0
                    : DIV_WIDTH'((1 << (div_code - 4'h1)) - 1);

  // Crystal is an outside clock; two flops before use, edges taken after sync
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      xtal_sync_reg <= 2'h0;
      xtal_prev_reg <= 1'b0;
    end
    else
    begin
      xtal_sync_reg <= {xtal_sync_reg[0], xtal_clk_in};
      xtal_prev_reg <= xtal_sync_reg[1];
    end
  end

  // System clock ticks every cycle; crystal only on synced rising edges, so
  // both sources divide alike (both edges would halve every crystal ratio)
  assign ref_tick = refctl_reg[`CTPM_REF_SEL_BIT]
                  ? (xtal_sync_reg[1] & ~xtal_prev_reg) : 1'b1;
  assign ref_run  = refctl_reg[`CTPM_REF_EN_BIT]
                  & (~in_sleep | refctl_reg[`CTPM_REF_SLP_BIT]);

  // Register writes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rc_trim_code <= `CTPM_TRIM_RESET;
      refctl_reg   <= `CTPM_REFCTL_RESET;
      resetctl_reg <= `CTPM_RESETCTL_RESET;
      oscctl_reg   <= `CTPM_OSCCTL_RESET;
    end
    else if (reg_write)
    begin
      if (addr_hit(reg_addr, `CTPM_ADDR_TRIM))
        rc_trim_code <= reg_wdata[5:0];
      if (addr_hit(reg_addr, `CTPM_ADDR_REFCTL))
      begin
        // Divider held while output is on; software must disable first
        if (refctl_reg[`CTPM_REF_EN_BIT])
          refctl_reg <= (reg_wdata & `CTPM_REFCTL_MASK & ~16'h0F00)
                      | (refctl_reg & 16'h0F00);
        else
          refctl_reg <= reg_wdata & `CTPM_REFCTL_MASK;
      end
      if (addr_hit(reg_addr, `CTPM_ADDR_RESETCTL))
        resetctl_reg <= reg_wdata & `CTPM_RESETCTL_MASK;
      // Only while running; a change in Sleep would alter the source resumed at wake
      if (addr_hit(reg_addr, `CTPM_ADDR_OSCCTL) && !clock_config_locked
          && state_reg == CTPM_RUN)
        oscctl_reg <= reg_wdata & `CTPM_OSCCTL_MASK;
    end
  end

  // Read data, one cycle after the strobe, zero for unmapped
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= 16'h0000;
    else if (reg_read)
    begin
      case (reg_addr)
        `CTPM_ADDR_TRIM:     reg_rdata <= {10'h000, rc_trim_code};
        `CTPM_ADDR_REFCTL:   reg_rdata <= refctl_reg;
        `CTPM_ADDR_RESETCTL: reg_rdata <= resetctl_reg;
        `CTPM_ADDR_OSCCTL:   reg_rdata <= oscctl_reg;
        `CTPM_ADDR_STATUS:   reg_rdata <= {12'h000, state_reg};
        default:             reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // Reference divider; counter restarts whenever the output is stopped
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_cnt_reg <= '0;
      ref_out_reg <= 1'b0;
    end
    else if (!ref_run)
    begin
      div_cnt_reg <= '0;
      ref_out_reg <= 1'b0;
    end
    else if (ref_tick)
    begin
      if (div_code == 4'h0)
        ref_out_reg <= ~ref_out_reg;
      else if (div_cnt_reg >= div_limit)
      begin
        div_cnt_reg <= '0;
        ref_out_reg <= ~ref_out_reg;
      end
      else
        div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  // Undivided system clock would need the clock itself; a toggle per cycle
  // gives half rate, the closest that a registered output can carry.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reference_clock_pin  <= 1'b0;
      reference_clock_oe_n <= 1'b1;
    end
    else
    begin
      reference_clock_pin  <= ref_out_reg & ref_run;
      reference_clock_oe_n <= ~refctl_reg[`CTPM_REF_EN_BIT];
    end
  end

  // Power mode sequencer. A wake event pending at entry is held until the
  // mode is reached, so the next cycle leaves it again.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CTPM_RUN:
        if (sleep_request)
          state_next = CTPM_SLEEP;
        else if (idle_request)
          state_next = CTPM_IDLE;
      CTPM_SLEEP:
        if (wake_event || wake_irq_reg)
          state_next = CTPM_WAKE;
      CTPM_IDLE:
        if (wake_event || wake_irq_reg)
          state_next = CTPM_WAKE;
      CTPM_WAKE:
        if (wake_cnt_reg == 2'(`CTPM_WAKE_CYCLES))
          state_next = CTPM_RUN;
      default:
        state_next = CTPM_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_reg <= CTPM_RUN;
    else
      state_reg <= state_next;
  end

  // Interrupt seen during entry is kept until wake
  always_ff @(posedge clk)
  begin
    if (srst)
      wake_irq_reg <= 1'b0;
    else if (state_reg == CTPM_RUN && (sleep_request || idle_request))
      wake_irq_reg <= wake_event;
    else if (state_next == CTPM_WAKE)
      wake_irq_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      wake_cnt_reg <= 2'h0;
    else if (state_reg == CTPM_WAKE)
      wake_cnt_reg <= wake_cnt_reg + 2'h1;
    else
      wake_cnt_reg <= 2'h0;
  end

  // Clock source at Sleep entry is held and restored on wake
  always_ff @(posedge clk)
  begin
    if (srst)
      sleep_osc_reg <= 3'h0;
    else if (state_reg == CTPM_RUN && sleep_request)
      sleep_osc_reg <= oscctl_reg[`CTPM_NEW_OSCILLATOR_SELECT_HI:`CTPM_NEW_OSCILLATOR_SELECT_LO];
  end

  // Registered power outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cpu_clock_enable        <= 1'b1;
      system_clock_enable     <= 1'b1;
      oscillator_enable       <= 1'b1;
      peripheral_clock_enable <= 1'b1;
      timer_clock_enable      <= 1'b1;
      clock_monitor_active    <= 1'b0;
      low_power_rc_enable     <= 1'b0;
      watchdog_clear          <= 1'b0;
      core_regulator_standby  <= 1'b0;
      flash_regulator_standby <= 1'b0;
      new_oscillator_select   <= 3'h0;
      resume_at_isr           <= 1'b0;
    end
    else
    begin
      cpu_clock_enable        <= (state_next == CTPM_RUN);
      system_clock_enable     <= (state_next != CTPM_SLEEP);
      oscillator_enable       <= (state_next != CTPM_SLEEP);
      peripheral_clock_enable <= (state_next != CTPM_SLEEP);
      timer_clock_enable      <= (state_next != CTPM_SLEEP)
                               & ~((state_next == CTPM_IDLE) & timer_stop_in_idle);
      clock_monitor_active    <= clock_monitor_enable & (state_next != CTPM_SLEEP);
      low_power_rc_enable     <= watchdog_enable
                               | ((state_next == CTPM_IDLE) & clock_monitor_enable)
                               | ((state_next == CTPM_RUN) & clock_monitor_enable);
      watchdog_clear          <= watchdog_enable & (state_reg == CTPM_RUN)
                               & (sleep_request | idle_request);
      core_regulator_standby  <= (state_next == CTPM_SLEEP)
                               & ~resetctl_reg[`CTPM_CORE_REG_BIT];
      flash_regulator_standby <= (state_next == CTPM_SLEEP)
                               & ~resetctl_reg[`CTPM_FLASH_REG_BIT];
      new_oscillator_select   <= (state_reg == CTPM_SLEEP || state_reg == CTPM_WAKE)
                               ? sleep_osc_reg
                               : oscctl_reg[`CTPM_NEW_OSCILLATOR_SELECT_HI:`CTPM_NEW_OSCILLATOR_SELECT_LO];
      if (state_next == CTPM_WAKE && state_reg != CTPM_WAKE)
        resume_at_isr <= wake_interrupt | wake_irq_reg;
    end
  end

  // Checks
  sequence s_enter_sleep;
    state_reg == CTPM_RUN && sleep_request;
  endsequence

  chk_sleep_stops_clock: assert property (@(posedge clk) disable iff (srst)
    s_enter_sleep |=> !system_clock_enable && !cpu_clock_enable)
    else $error("system clock still on after sleep entry");

  chk_idle_keeps_clock: assert property (@(posedge clk) disable iff (srst)
    (state_reg == CTPM_RUN && !sleep_request && idle_request)
      |=> !cpu_clock_enable && system_clock_enable)
    else $error("idle entry clock state wrong");

  chk_wake_leaves_mode: assert property (@(posedge clk) disable iff (srst)
    ((in_sleep || in_idle) && wake_event) |=> state_reg == CTPM_WAKE)
    else $error("wake event did not leave power mode");

  chk_idle_wake_delay: assert property (@(posedge clk) disable iff (srst)
    (in_idle && wake_event) |=> !cpu_clock_enable ##1 !cpu_clock_enable
      ##[0:2] cpu_clock_enable)
    else $error("cpu clock not back within 2-4 cycles");

  chk_watchdog_clear: assert property (@(posedge clk) disable iff (srst)
    (s_enter_sleep ##0 watchdog_enable) |=> watchdog_clear)
    else $error("watchdog not cleared on sleep entry");

  chk_regulator_keep: assert property (@(posedge clk) disable iff (srst)
    (in_sleep && $past(in_sleep) && !resetctl_reg[`CTPM_CORE_REG_BIT])
      |-> core_regulator_standby)
    else $error("core regulator not in standby during sleep");

  chk_monitor_sleep: assert property (@(posedge clk) disable iff (srst)
    (in_sleep && $past(in_sleep)) |-> !clock_monitor_active)
    else $error("clock monitor active in sleep");

  chk_ref_off_pin: assert property (@(posedge clk) disable iff (srst)
    !refctl_reg[`CTPM_REF_EN_BIT] |=> reference_clock_oe_n && !reference_clock_pin)
    else $error("reference pin driven while disabled");

  chk_trim_follows: assert property (@(posedge clk) disable iff (srst)
    (reg_write && reg_addr == `CTPM_ADDR_TRIM) |=> rc_trim_code == $past(reg_wdata[5:0]))
    else $error("trim code did not follow write");

endmodule : ctpm_clock_power

// file: ctpm_clock_power_tb_top.sv
// Self-checking bench for the clock trim, reference output and power mode block.
// Assumes ctpm_pkg and ctpm_defs.svh are compiled first; bench drives every port.
`include "ctpm_defs.svh"

module ctpm_clock_power_tb_top
  import ctpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        srst;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_write;
  logic        reg_read;
  logic        xtal_clk_in;
  logic        xtal_run;
  logic        sleep_request;
  logic        idle_request;
  logic        wake_interrupt;
  logic        wake_reset;
  logic        watchdog_timeout;
  logic        watchdog_enable;
  logic        clock_monitor_enable;
  logic        clock_config_locked;
  logic        timer_stop_in_idle;
  logic [5:0]  rc_trim_code;
  logic        reference_clock_pin;
  logic        reference_clock_oe_n;
  logic        cpu_clock_enable;
  logic        system_clock_enable;
  logic        oscillator_enable;
  logic        peripheral_clock_enable;
  logic        timer_clock_enable;
  logic        clock_monitor_active;
  logic        low_power_rc_enable;
  logic        watchdog_clear;
  logic        core_regulator_standby;
  logic        flash_regulator_standby;
  logic [2:0]  new_oscillator_select;
  logic        resume_at_isr;
  logic [15:0] rd;
  int          err_count;
  int          total_checks;
  int          cycles;

  ctpm_clock_power u_dut
  (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .xtal_clk_in(xtal_clk_in), .sleep_request(sleep_request), .idle_request(idle_request),
    .wake_interrupt(wake_interrupt), .wake_reset(wake_reset),
    .watchdog_timeout(watchdog_timeout), .watchdog_enable(watchdog_enable),
    .clock_monitor_enable(clock_monitor_enable), .clock_config_locked(clock_config_locked),
    .timer_stop_in_idle(timer_stop_in_idle), .rc_trim_code(rc_trim_code),
    .reference_clock_pin(reference_clock_pin), .reference_clock_oe_n(reference_clock_oe_n),
    .cpu_clock_enable(cpu_clock_enable), .system_clock_enable(system_clock_enable),
    .oscillator_enable(oscillator_enable), .peripheral_clock_enable(peripheral_clock_enable),
    .timer_clock_enable(timer_clock_enable), .clock_monitor_active(clock_monitor_active),
    .low_power_rc_enable(low_power_rc_enable), .watchdog_clear(watchdog_clear),
    .core_regulator_standby(core_regulator_standby),
    .flash_regulator_standby(flash_regulator_standby),
    .new_oscillator_select(new_oscillator_select), .resume_at_isr(resume_at_isr)
  );

  always #5 clk = ~clk;
  // 36 ns half period never lands on a clock edge at 5 + 10k ns
  always #36 if (xtal_run) xtal_clk_in = ~xtal_clk_in;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  task automatic rdr(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rdr

  task automatic count_tg(input int n, output int t);
    logic p;
    t = 0;
    @(posedge clk);
    #1 p = reference_clock_pin;
    repeat (n)
    begin
      @(posedge clk);
      #1 if (reference_clock_pin !== p) t++;
      p = reference_clock_pin;
    end
  endtask : count_tg

  // Counts edges after the wake edge until the CPU clock returns
  task automatic wait_cpu(output int n);
    n = 0;
    #1;
    while (cpu_clock_enable !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_cpu

  task automatic t_reset();
    rdr(4'h0, rd);
    chk(rd, 16'h0000, "trim reset");
    rdr(4'h1, rd);
    chk(rd, 16'h0000, "refctl reset");
    rdr(4'h4, rd);
    chk(rd, 16'(CTPM_RUN), "status run");
    rdr(4'hF, rd);
    chk(rd, 16'h0000, "unmapped read");
    chk(reference_clock_oe_n, 1'b1, "oe after reset");
    $display("reset test done");
  endtask : t_reset

  task automatic t_trim();
    wr(4'h0, 16'hFFE0);
    rdr(4'h0, rd);
    chk(rd, 16'h0020, "trim readback");
    chk(rc_trim_code, 6'h20, "trim out neg");
    wr(4'h0, 16'h001F);
    chk(rc_trim_code, 6'h1F, "trim out pos");
    $display("trim test done");
  endtask : t_trim

  task automatic t_refout();
    logic [3:0] codes[3] = '{4'h0, 4'h2, 4'h3};
    int exp[3] = '{16, 8, 4};
    int t;
    foreach (codes[i])
    begin
      wr(4'h1, {4'h0, codes[i], 8'h00});
      wr(4'h1, {4'h8, codes[i], 8'h00});
      count_tg(16, t);
      chk(reference_clock_oe_n, 1'b0, "oe enabled");
      chk(16'(t), 16'(exp[i]), "divider toggles");
    end
    wr(4'h1, 16'h8500);
    rdr(4'h1, rd);
    chk(rd, 16'h8300, "divider write while on");
    wr(4'h1, 16'h0000);
    @(posedge clk);
    #1 chk(reference_clock_oe_n, 1'b1, "oe disabled");
    wr(4'h1, 16'h1000);
    wr(4'h1, 16'h9000);
    count_tg(16, t);
    chk(16'(t), 16'h0000, "crystal idle");
    xtal_run = 1'b1;
    count_tg(40, t);
    chk(16'(t > 0 && t < 20), 16'h0001, "crystal ticks");
    xtal_run = 1'b0;
    wr(4'h1, 16'h0000);
    $display("reference output test done");
  endtask : t_refout

  task automatic t_sleep(input logic [15:0] refv, input logic [15:0] rstv);
    int t;
    int n;
    wr(4'h1, refv);
    wr(4'h2, rstv);
    wr(4'h3, 16'h0500);
    watchdog_enable <= 1'b1;
    clock_monitor_enable <= 1'b1;
    @(posedge clk);
    sleep_request <= 1'b1;
    @(posedge clk);
    sleep_request <= 1'b0;
    #1 chk(watchdog_clear, 1'b1, "wdt clear sleep");
    chk({system_clock_enable, oscillator_enable, cpu_clock_enable}, 3'h0, "sleep clocks");
    chk(peripheral_clock_enable, 1'b0, "sleep periph");
    chk(clock_monitor_active, 1'b0, "monitor in sleep");
    chk(low_power_rc_enable, 1'b1, "low_power_rc_oscillator in sleep");
    chk({core_regulator_standby, flash_regulator_standby}, {~rstv[8], ~rstv[11]}, "regs");
    count_tg(8, t);
    chk(16'(t), refv[13] ? 16'h0008 : 16'h0000, "pin in sleep");
    wr(4'h3, 16'h0200);
    chk(new_oscillator_select, 3'h5, "saved source");
    @(posedge clk);
    wake_interrupt <= 1'b1;
    @(posedge clk);
    wake_interrupt <= 1'b0;
    wait_cpu(n);
    chk(16'(n >= 2 && n <= 4), 16'h0001, "sleep wake delay");
    chk(resume_at_isr, 1'b1, "isr resume");
    chk(new_oscillator_select, 3'h5, "source after wake");
    watchdog_enable <= 1'b0;
    wr(4'h1, 16'h0000);
    $display("sleep test done");
  endtask : t_sleep

  task automatic t_idle(input int src, input logic wdt);
    int n;
    watchdog_enable <= wdt;
    clock_monitor_enable <= ~wdt;
    timer_stop_in_idle <= wdt;
    @(posedge clk);
    idle_request <= 1'b1;
    @(posedge clk);
    idle_request <= 1'b0;
    #1 chk(watchdog_clear, wdt, "wdt clear idle");
    chk({cpu_clock_enable, system_clock_enable, peripheral_clock_enable}, 3'h3, "idle");
    chk(timer_clock_enable, !wdt, "timer stop idle");
    chk(low_power_rc_enable, 1'b1, "low_power_rc_oscillator in idle");
    rdr(4'h4, rd);
    chk(rd, 16'(CTPM_IDLE), "status idle");
    @(posedge clk);
    wake_interrupt <= (src == 0);
    wake_reset <= (src == 1);
    watchdog_timeout <= (src == 2);
    @(posedge clk);
    {wake_interrupt, wake_reset, watchdog_timeout} <= 3'h0;
    wait_cpu(n);
    chk(16'(n >= 2 && n <= 4), 16'h0001, "idle wake delay");
    chk(resume_at_isr, src == 0, "resume point");
    watchdog_enable <= 1'b0;
    $display("idle test done");
  endtask : t_idle

  task automatic t_coincide();
    int n;
    @(posedge clk);
    idle_request <= 1'b1;
    wake_interrupt <= 1'b1;
    @(posedge clk);
    idle_request <= 1'b0;
    wake_interrupt <= 1'b0;
    #1 chk(cpu_clock_enable, 1'b0, "entry completes");
    wait_cpu(n);
    chk(16'(n <= 6), 16'h0001, "deferred wake");
    $display("coincident test done");
  endtask : t_coincide

  task automatic t_osclock();
    logic [15:0] old;
    rdr(4'h3, old);
    clock_config_locked <= 1'b1;
    wr(4'h3, 16'h0300);
    rdr(4'h3, rd);
    chk(rd, old, "locked write");
    clock_config_locked <= 1'b0;
    wr(4'h3, 16'h0300);
    rdr(4'h3, rd);
    chk(rd, 16'h0300, "unlocked write");
    chk(new_oscillator_select, 3'h3, "select out");
    $display("oscillator select test done");
  endtask : t_osclock

  task automatic t_midreset();
    wr(4'h0, 16'h0015);
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1 chk(rc_trim_code, 6'h00, "trim after reset");
    chk(reference_clock_oe_n, 1'b1, "oe after mid reset");
    rdr(4'h4, rd);
    chk(rd, 16'(CTPM_RUN), "status after mid reset");
    $display("mid-run reset test done");
  endtask : t_midreset

  initial
  begin
    srst = 1'b1;
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    {xtal_clk_in, xtal_run, sleep_request, idle_request} = '0;
    {wake_interrupt, wake_reset, watchdog_timeout, watchdog_enable} = '0;
    {clock_monitor_enable, clock_config_locked, timer_stop_in_idle} = '0;
    err_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_trim();
    t_refout();
    t_sleep(16'h8000, 16'h0100);
    t_sleep(16'hA000, 16'h0800);
    t_idle(0, 1'b0);
    t_idle(1, 1'b1);
    t_idle(2, 1'b0);
    t_coincide();
    t_osclock();
    t_midreset();
    end_of_test();
  end

endmodule : ctpm_clock_power_tb_top

// file: ctpm_defs.svh
// Constants for the clock trim, reference output and power mode block.
// Assumes a 100 MHz system clock and a plain strobe register port.
// Operation
// - Six-bit signed oscillator trim, 0 centre, 011111 max up, 100000 max down.
// - Reference output enable bit 15 drives divided clock onto the reference pin.
// - Run-in-sleep bit 13 keeps reference output toggling in Sleep, else stopped.
// - Source select bit 12 picks crystal when set, system clock when clear.
// - Divider bits 11:8, zero passes through, n divides by two to the n. Here zero toggles every tick, giving half rate.
// - Sleep request stops system clock source, on-chip oscillator and execution.
// - Idle request stops CPU, keeps system clock so peripherals run.
// - Leave Sleep or Idle on enabled interrupt, any reset or watchdog time-out.
// - Fail-safe clock monitor is disabled during Sleep.
// - Low-power RC oscillator runs in Sleep when watchdog enabled.
// - Watchdog count cleared automatically on entering Sleep or Idle.
// - Sleep disables system-clocked peripherals; pin change and external-clock ones run.
// - Wake from Sleep resumes with the clock source active at entry.
// - Core and flash regulators standby in Sleep unless their keep-active bits set.
// - Low-power RC runs in Idle when watchdog or clock monitor enabled.
// - Wake from Idle restarts CPU clock, execution begins 2-4 cycles later.
// - Peripheral stop-in-idle bit halts that peripheral during Idle.
// - Unlocked clock configuration lets software write new oscillator select 10:8.
// - Interrupt during power-save instruction deferred until mode entry completes, then wakes.
`ifndef CTPM_DEFS_SVH
`define CTPM_DEFS_SVH

`define CTPM_ADDR_TRIM       4'h0
`define CTPM_ADDR_REFCTL     4'h1
`define CTPM_ADDR_RESETCTL   4'h2
`define CTPM_ADDR_OSCCTL     4'h3
`define CTPM_ADDR_STATUS     4'h4

`define CTPM_REF_EN_BIT      15
`define CTPM_REF_SLP_BIT     13
`define CTPM_REF_SEL_BIT     12
`define CTPM_REF_DIV_HI      11
`define CTPM_REF_DIV_LO      8
`define CTPM_REFCTL_MASK     16'hBF00
`define CTPM_TRIM_MASK       16'h003F
`define CTPM_CORE_REG_BIT    8
`define CTPM_FLASH_REG_BIT   11
`define CTPM_RESETCTL_MASK   16'h0900
`define CTPM_NEW_OSCILLATOR_SELECT_HI         10
`define CTPM_NEW_OSCILLATOR_SELECT_LO         8
`define CTPM_OSCCTL_MASK     16'h0700

`define CTPM_TRIM_RESET      6'h00
`define CTPM_REFCTL_RESET    16'h0000
`define CTPM_RESETCTL_RESET  16'h0000
`define CTPM_OSCCTL_RESET    16'h0000

`define CTPM_WAKE_DELAY_NS   20
`define CTPM_CLK_PERIOD_NS   10
`define CTPM_WAKE_CYCLES     (`CTPM_WAKE_DELAY_NS / `CTPM_CLK_PERIOD_NS)

`endif

// file: ctpm_pkg.sv
// Types for the clock trim, reference output and power mode block.
// Assumes ctpm_defs.svh carries all numeric constants other than the state codes below.
package ctpm_pkg;

  typedef enum logic [3:0]
  {
    CTPM_RUN   = 4'h1,
    CTPM_SLEEP = 4'h2,
    CTPM_IDLE  = 4'h4,
    CTPM_WAKE  = 4'h8
  } ctpm_state_type;

endpackage : ctpm_pkg
